//--- hw/cpcond_pkg.sv
// Shared constants and types for the coprocessor conditional sequencer.
package cpcond_pkg;
    localparam logic [3:0] CPCOND_FLINE = 4'hf;
    localparam int CPCOND_SEL_HI = 11;
    localparam int CPCOND_SEL_LO = 9;
    localparam logic [2:0] CPCOND_TYPE_BR_W = 3'h2;
    localparam logic [2:0] CPCOND_TYPE_BR_L = 3'h3;
    localparam logic [2:0] CPCOND_TYPE_SET = 3'h1;
    localparam logic [5:0] CPCOND_TYPE_DEC = 6'h09;
    localparam logic [7:0] CPCOND_BYTE_TRUE = 8'hff;
    localparam logic [7:0] CPCOND_BYTE_FALSE = 8'h00;
    localparam logic [15:0] CPCOND_MINUS_ONE = 16'hffff;
    // Response word fields: bit 15 come-again, bits 12..8 primitive code.
    localparam int CPCOND_RSP_CA = 15;
    localparam logic [4:0] CPCOND_PRIM_NULL = 5'h08;
    localparam int CPCOND_RSP_TRUE = 0;
    // Register map of the plain software port.
    localparam logic [3:0] CPCOND_A_OPWORD = 4'h0;
    localparam logic [3:0] CPCOND_A_EXTCNT = 4'h1;
    localparam logic [3:0] CPCOND_A_SCAN = 4'h2;
    localparam logic [3:0] CPCOND_A_STATUS = 4'h3;
    localparam logic [3:0] CPCOND_A_TARGET = 4'h4;
    localparam logic [3:0] CPCOND_A_COUNT = 4'h5;
    localparam logic [3:0] CPCOND_A_EAWORDS = 4'h6;
    localparam int CPCOND_NREG = 8;
    typedef enum logic [1:0] {
        CPCOND_K_NONE,
        CPCOND_K_BRANCH,
        CPCOND_K_SET,
        CPCOND_K_DEC
    } cpcond_kind_t;
endpackage

//--- hw/cpcond_regfile.sv
`timescale 1ns/1ps
// Small register file holding the eight loop counter data registers.
module cpcond_regfile (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [2:0] raddr,
    output logic [31:0] rdata
);
    import cpcond_pkg::*;
    typedef struct packed {
        logic [7:0][31:0] mem;
        logic [31:0] rd;
    } cpcond_rf_t;
    cpcond_rf_t s_q;
    cpcond_rf_t s_d;
    always_comb begin
        s_d = s_q;
        if (we) begin
            s_d.mem[waddr] = wdata;
        end
        s_d.rd = s_d.mem[raddr];
    end
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign rdata = s_q.rd;
endmodule

//--- hw/cpcond_core.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
// Main-processor sequencer for coprocessor conditional instructions.
module cpcond_core (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [15:0] istream_word,
    output logic istream_req,
    output logic [31:0] instruction_scan_pointer,
    output logic cir_wr,
    output logic [15:0] cir_wdata,
    output logic [2:0] coproc_select_code,
    output logic rsp_rd,
    input wire logic [15:0] rsp_data,
    output logic service_req,
    input wire logic service_done,
    output logic byte_wr,
    output logic [7:0] byte_data,
    output logic protocol_violation,
    output logic done
);
    import cpcond_pkg::*;
    typedef enum logic [3:0] {
        CPCOND_IDLE, CPCOND_SEL, CPCOND_CIR, CPCOND_RSP, CPCOND_SVC,
        CPCOND_EXT, CPCOND_DHI, CPCOND_DLO, CPCOND_EAW, CPCOND_FIN,
        CPCOND_DECW, CPCOND_END
    } cpcond_state_t;
    typedef struct packed {
        cpcond_state_t st;
        cpcond_kind_t kind;
        logic long_d;
        logic [15:0] op;
        logic [15:0] cond;
        logic [3:0] ext_cnt;
        logic [3:0] left;
        logic [2:0] ea_cnt;
        logic [31:0] scan;
        logic [31:0] disp_base;
        logic [31:0] disp;
        logic [31:0] target;
        logic result;
        logic viol;
        logic busy;
        logic [31:0] rdata;
        logic cir_wr;
        logic rsp_rd;
        logic byte_wr;
        logic done;
    } cpcond_st_t;
    cpcond_st_t s_q;
    cpcond_st_t s_d;
    logic rf_we;
    logic [31:0] rf_rdata;
    logic [31:0] dec_val;

    // Decodes an operation word into its instruction kind.
    function automatic cpcond_kind_t decode(input logic [15:0] w);
        cpcond_kind_t k;
        k = CPCOND_K_NONE;
        if (w[15:12] == CPCOND_FLINE) begin
            if (w[8:3] == CPCOND_TYPE_DEC) begin
                k = CPCOND_K_DEC;
            end else if (w[8:6] == CPCOND_TYPE_SET) begin
                k = CPCOND_K_SET;
            end else if (w[8:6] == CPCOND_TYPE_BR_W ||
                         w[8:6] == CPCOND_TYPE_BR_L) begin
                k = CPCOND_K_BRANCH;
            end
        end
        return k;
    endfunction

    // Sign-extends a word to a long word.
    function automatic logic [31:0] sext(input logic [15:0] w);
        return {{16{w[15]}}, w};
    endfunction

    assign dec_val = {rf_rdata[31:16], rf_rdata[15:0] - 16'h0001};
    assign rf_we = s_q.st == CPCOND_DECW;

    cpcond_regfile u_rf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .we(rf_we),
        .waddr(s_q.op[2:0]),
        .wdata(dec_val),
        .raddr(s_q.op[2:0]),
        .rdata(rf_rdata)
    );

    always_comb begin
        s_d = s_q;
        s_d.cir_wr = 1'b0;
        s_d.rsp_rd = 1'b0;
        s_d.byte_wr = 1'b0;
        s_d.done = 1'b0;
        s_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                CPCOND_A_OPWORD: s_d.rdata = {16'h0000, s_q.op};
                CPCOND_A_EXTCNT: s_d.rdata = {28'h0, s_q.ext_cnt};
                CPCOND_A_SCAN: s_d.rdata = s_q.scan;
                CPCOND_A_STATUS: s_d.rdata = {28'h0, s_q.busy, s_q.viol,
                                              s_q.result, s_q.done};
                CPCOND_A_TARGET: s_d.rdata = s_q.target;
                CPCOND_A_COUNT: s_d.rdata = rf_rdata;
                CPCOND_A_EAWORDS: s_d.rdata = {29'h0, s_q.ea_cnt};
                default: s_d.rdata = '0;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                CPCOND_A_EXTCNT: s_d.ext_cnt = reg_wdata[3:0];
                CPCOND_A_SCAN: s_d.scan = reg_wdata;
                // Up to five address words; larger values of bits 2..0 saturate.
                CPCOND_A_EAWORDS: s_d.ea_cnt = (reg_wdata[2:0] > 3'h5) ?
                                               3'h5 : reg_wdata[2:0];
                default: ;
            endcase
        end
        case (s_q.st)
            CPCOND_IDLE: begin
                if (istream_word != 16'h0000 && !s_q.busy) begin
                    s_d.op = istream_word;
                    s_d.kind = decode(istream_word);
                    s_d.long_d = istream_word[6];
                    s_d.scan = s_q.scan + 32'h2;
                    s_d.viol = 1'b0;
                    if (decode(istream_word) != CPCOND_K_NONE) begin
                        s_d.busy = 1'b1;
                        s_d.cond = istream_word;
                        s_d.st = (decode(istream_word) == CPCOND_K_BRANCH) ?
                                 CPCOND_CIR : CPCOND_SEL;
                    end
                end
            end
            CPCOND_SEL: begin
                s_d.cond = istream_word;
                s_d.scan = s_q.scan + 32'h2;
                s_d.st = CPCOND_CIR;
            end
            CPCOND_CIR: begin
                s_d.cir_wr = 1'b1;
                s_d.st = CPCOND_RSP;
            end
            CPCOND_RSP: begin
                s_d.rsp_rd = 1'b1;
                if (s_q.rsp_rd) begin
                    s_d.rsp_rd = 1'b0;
                    if (rsp_data[12:8] == CPCOND_PRIM_NULL) begin
                        s_d.result = rsp_data[CPCOND_RSP_TRUE];
                        s_d.left = s_q.ext_cnt;
                        s_d.st = CPCOND_EXT;
                    end else if (!rsp_data[CPCOND_RSP_CA]) begin
                        s_d.viol = 1'b1;
                        s_d.st = CPCOND_END;
                    end else begin
                        s_d.st = CPCOND_SVC;
                    end
                end
            end
            CPCOND_SVC: begin
                if (service_done) begin
                    s_d.st = CPCOND_RSP;
                end
            end
            CPCOND_EXT: begin
                if (s_q.left != 4'h0) begin
                    s_d.left = s_q.left - 4'h1;
                    s_d.scan = s_q.scan + 32'h2;
                end else begin
                    s_d.disp_base = s_q.scan;
                    s_d.left = {1'b0, s_q.ea_cnt};
                    s_d.st = (s_q.kind == CPCOND_K_SET) ?
                             CPCOND_EAW : CPCOND_DHI;
                end
            end
            CPCOND_DHI: begin
                s_d.scan = s_q.scan + 32'h2;
                s_d.disp = sext(istream_word);
                s_d.st = (s_q.kind == CPCOND_K_BRANCH && s_q.long_d) ?
                         CPCOND_DLO : CPCOND_FIN;
            end
            CPCOND_DLO: begin
                s_d.scan = s_q.scan + 32'h2;
                s_d.disp = {s_q.disp[15:0], istream_word};
                s_d.st = CPCOND_FIN;
            end
            CPCOND_EAW: begin
                if (s_q.left != 4'h0) begin
                    s_d.left = s_q.left - 4'h1;
                    s_d.scan = s_q.scan + 32'h2;
                end else begin
                    s_d.st = CPCOND_FIN;
                end
            end
            CPCOND_FIN: begin
                s_d.target = s_q.disp_base + s_q.disp;
                s_d.st = CPCOND_END;
                case (s_q.kind)
                    CPCOND_K_BRANCH: begin
                        if (s_q.result) begin
                            s_d.scan = s_q.disp_base + s_q.disp;
                        end
                    end
                    CPCOND_K_SET: begin
                        s_d.byte_wr = 1'b1;
                    end
                    CPCOND_K_DEC: begin
                        if (!s_q.result) begin
                            s_d.st = CPCOND_DECW;
                        end
                    end
                    default: ;
                endcase
            end
            CPCOND_DECW: begin
                // branch unless counter reached minus one.
                if (dec_val[15:0] != CPCOND_MINUS_ONE) begin
                    s_d.scan = s_q.target;
                end
                s_d.st = CPCOND_END;
            end
            CPCOND_END: begin
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.st = CPCOND_IDLE;
            end
            default: s_d.st = CPCOND_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign instruction_scan_pointer = s_q.scan;
    assign cir_wr = s_q.cir_wr;
    assign cir_wdata = s_q.cond;
    assign coproc_select_code = s_q.op[CPCOND_SEL_HI:CPCOND_SEL_LO];
    assign rsp_rd = s_q.rsp_rd;
    assign service_req = s_q.st == CPCOND_SVC;
    assign byte_wr = s_q.byte_wr;
    assign byte_data = s_q.result ? CPCOND_BYTE_TRUE : CPCOND_BYTE_FALSE;
    assign protocol_violation = s_q.viol;
    assign done = s_q.done;
    assign istream_req = s_q.st == CPCOND_SEL || s_q.st == CPCOND_DHI ||
                         s_q.st == CPCOND_DLO ||
                         ((s_q.st == CPCOND_EXT || s_q.st == CPCOND_EAW) &&
                          s_q.left != 4'h0);

    property p_viol;
        @(posedge clk_sys) disable iff (!rstn)
        rsp_rd && rsp_data[12:8] != CPCOND_PRIM_NULL &&
        !rsp_data[CPCOND_RSP_CA] |=> protocol_violation;
    endproperty
    a_viol: assert property (p_viol) else $error("missed violation");
    property p_setbyte;
        @(posedge clk_sys) disable iff (!rstn)
        byte_wr |-> byte_data == (s_q.result ? 8'hff : 8'h00);
    endproperty
    a_setbyte: assert property (p_setbyte) else $error("bad byte");
    property p_cirw;
        @(posedge clk_sys) disable iff (!rstn)
        cir_wr |=> rsp_rd;
    endproperty
    a_cirw: assert property (p_cirw) else $error("no response read");
    property p_branch;
        @(posedge clk_sys) disable iff (!rstn)
        s_q.st == CPCOND_FIN && s_q.kind == CPCOND_K_BRANCH && s_q.result
        |=> instruction_scan_pointer == $past(s_q.disp_base + s_q.disp);
    endproperty
    a_branch: assert property (p_branch) else $error("bad target");
    property p_sext;
        @(posedge clk_sys) disable iff (!rstn)
        s_q.st == CPCOND_DHI |=> s_q.disp[31:15] == {17{s_q.disp[15]}};
    endproperty
    a_sext: assert property (p_sext) else $error("no sign extend");
    property p_sel;
        @(posedge clk_sys) disable iff (!rstn)
        s_q.st == CPCOND_IDLE && decode(istream_word) == CPCOND_K_BRANCH
        && !s_q.busy |=> ##1 cir_wr && cir_wdata == $past(istream_word, 2);
    endproperty
    a_sel: assert property (p_sel) else $error("bad selector");
    property p_ndec;
        @(posedge clk_sys) disable iff (!rstn)
        s_q.st == CPCOND_FIN && s_q.kind == CPCOND_K_DEC && s_q.result
        |=> done == 1'b0 ##1 done;
    endproperty
    a_ndec: assert property (p_ndec) else $error("true loop bad");
    property p_ext;
        @(posedge clk_sys) disable iff (!rstn)
        s_q.st == CPCOND_EXT && s_q.left != 4'h0
        |=> instruction_scan_pointer == $past(instruction_scan_pointer) + 2;
    endproperty
    a_ext: assert property (p_ext) else $error("ext skip bad");
    c_br: cover property (@(posedge clk_sys) cir_wr ##[1:20] done);
    c_set: cover property (@(posedge clk_sys) byte_wr);
    c_dec: cover property (@(posedge clk_sys) rf_we);
    c_viol: cover property (@(posedge clk_sys) protocol_violation);
endmodule

//--- tb/cpcond_cop_model.sv
// Behavioural coprocessor that evaluates conditions for the sequencer.
`timescale 1ns/1ps
module cpcond_cop_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cir_wr,
    input wire logic [15:0] cir_wdata,
    input wire logic [2:0] coproc_select_code,
    input wire logic rsp_rd,
    output logic [15:0] rsp_data,
    input wire logic service_req,
    output logic service_done,
    input wire logic [2:0] mode,
    output logic [15:0] cir_word,
    output logic [2:0] sel,
    output int cir_cnt
);
    import cpcond_pkg::*;
    int rd_cnt;
    logic [1:0] svc_cnt;
    logic [15:0] rsp_word;
    // Mode bit 0 is the outcome, bit 1 asks one service round first,
    // bit 2 sends a service code that wrongly lacks come-again.
    always_comb begin
        if (mode[2]) begin
            rsp_word = {3'h0, 5'h01, 8'h00};
        end else if (mode[1] && rd_cnt == 0) begin
            rsp_word = {1'b1, 2'h0, 5'h01, 8'h00};
        end else begin
            rsp_word = {3'h0, CPCOND_PRIM_NULL, 7'h00, mode[0]};
        end
    end
    // Only a read sees the response, so a late sample gets the inverse.
    assign rsp_data = rsp_rd ? rsp_word : ~rsp_word;
    always @(posedge clk_sys) begin
        if (!rstn) begin
            cir_word <= 16'h0000;
            sel <= 3'h0;
            cir_cnt <= 0;
            rd_cnt <= 0;
            svc_cnt <= 2'h0;
            service_done <= 1'b0;
        end else begin
            if (cir_wr) begin
                cir_word <= cir_wdata;
                sel <= coproc_select_code;
                cir_cnt <= cir_cnt + 1;
                rd_cnt <= 0;
            end
            if (rsp_rd) begin
                rd_cnt <= rd_cnt + 1;
            end
            // Service is answered slowly, three cycles after the request.
            svc_cnt <= service_req ? svc_cnt + 2'h1 : 2'h0;
            service_done <= service_req && svc_cnt == 2'h2;
        end
    end
endmodule

//--- tb/cpcond_core_tb.sv
// Self-checking testbench for the coprocessor conditional sequencer.
`timescale 1ns/1ps
module cpcond_core_tb;
    import cpcond_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] istream_word = 16'h0;
    logic istream_req, cir_wr, rsp_rd, service_req, service_done;
    logic [31:0] instruction_scan_pointer;
    logic [15:0] cir_wdata, rsp_data, cir_word;
    logic [2:0] coproc_select_code, sel;
    logic byte_wr, protocol_violation, done, saw_byte;
    logic [7:0] byte_data, got_byte;
    logic [2:0] mode = 3'h0;
    logic [15:0] wq [0:2];
    int idx, nw_q, cir_cnt;
    int n_mismatch = 0;
    int cmp_count = 0;
    cpcond_core uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .istream_word(istream_word),
        .istream_req(istream_req),
        .instruction_scan_pointer(instruction_scan_pointer),
        .cir_wr(cir_wr), .cir_wdata(cir_wdata),
        .coproc_select_code(coproc_select_code), .rsp_rd(rsp_rd),
        .rsp_data(rsp_data), .service_req(service_req),
        .service_done(service_done), .byte_wr(byte_wr),
        .byte_data(byte_data), .protocol_violation(protocol_violation),
        .done(done));
    cpcond_cop_model cop (.clk_sys(clk_sys), .rstn(rstn), .cir_wr(cir_wr),
        .cir_wdata(cir_wdata), .coproc_select_code(coproc_select_code),
        .rsp_rd(rsp_rd), .rsp_data(rsp_data), .service_req(service_req),
        .service_done(service_done), .mode(mode), .cir_word(cir_word),
        .sel(sel), .cir_cnt(cir_cnt));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Words after the operation word advance only when consumed.
    always @(posedge clk_sys) begin
        if (istream_req === 1'b1) begin
            idx <= idx + 1;
            istream_word <= (idx + 1 < nw_q) ? wq[idx + 1] : 16'h0;
        end
        if (byte_wr === 1'b1) begin
            saw_byte <= 1'b1;
            got_byte <= byte_data;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // One idle cycle keeps the next strobe out of this time step.
        @(posedge clk_sys);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        // Read data stand only in the cycle after the strobe.
        @(posedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    task automatic run_ins(input logic [15:0] op, input int nw,
        input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] m,
        input logic [31:0] exp_pc, input logic [15:0] exp_cir,
        input logic [8:0] bexp, input logic viol);
        int k;
        int c0;
        wr(CPCOND_A_SCAN, 32'h1000);
        c0 = cir_cnt;
        saw_byte = 1'b0;
        got_byte = 8'h00;
        wq[0] = w0;
        wq[1] = w1;
        nw_q = nw;
        mode <= m;
        istream_word <= op;
        @(posedge clk_sys);
        idx = 0;
        istream_word <= w0;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            if (done === 1'b1 || protocol_violation === 1'b1) break;
        end
        if (k == 100) begin
            n_mismatch++;
            $display("[FAIL] %0t instruction did not end", $time);
        end
        chk(protocol_violation, viol);
        if (!viol) chk(instruction_scan_pointer, exp_pc);
        chk(cir_cnt - c0, 1);
        chk({sel, cir_word}, {op[11:9], exp_cir});
        chk({saw_byte, got_byte}, bexp);
        istream_word <= 16'h0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic ignored(input logic [15:0] op);
        int c0;
        wr(CPCOND_A_SCAN, 32'h1000);
        c0 = cir_cnt;
        istream_word <= op;
        @(posedge clk_sys);
        istream_word <= 16'h0;
        repeat (6) @(posedge clk_sys);
        chk(instruction_scan_pointer, 32'h1002);
        chk(cir_cnt - c0, 0);
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk(instruction_scan_pointer, 32'h0);
        rdc(CPCOND_A_STATUS, 32'h0);
        rdc(4'h7, 32'h0);
        wr(CPCOND_A_EXTCNT, 32'h1);
        // short branch back over one extension word
        run_ins(16'hfa95, 2, 16'habcd, 16'hfff0, 3'h1, 32'h0ff4, 16'hfa95,
            9'h0, 1'b0);
        wr(CPCOND_A_OPWORD, 32'h1111);
        rdc(CPCOND_A_OPWORD, 32'hfa95);
        wr(CPCOND_A_EXTCNT, 32'h0);
        run_ins(16'hf2ea, 2, 16'h0001, 16'h0000, 3'h1, 32'h11002, 16'hf2ea,
            9'h0, 1'b0);
        run_ins(16'hfa95, 1, 16'h0010, 16'h0, 3'h2, 32'h1004, 16'hfa95,
            9'h0, 1'b0);
        // set byte with one address word
        wr(CPCOND_A_EAWORDS, 32'h1);
        run_ins(16'hfe68, 2, 16'h0012, 16'h1234, 3'h1, 32'h1006, 16'h0012,
            9'h1ff, 1'b0);
        run_ins(16'hfe68, 2, 16'h0012, 16'h1234, 3'h2, 32'h1006, 16'h0012,
            9'h100, 1'b0);
        // counter 0 falls, then -1 branches
        run_ins(16'hf44b, 2, 16'h0005, 16'hfffa, 3'h0, 32'h1006, 16'h0005,
            9'h0, 1'b0);
        run_ins(16'hf44b, 2, 16'h0005, 16'hfffa, 3'h1, 32'h1006, 16'h0005,
            9'h0, 1'b0);
        run_ins(16'hf44b, 2, 16'h0005, 16'hfffa, 3'h0, 32'h0ffe, 16'h0005,
            9'h0, 1'b0);
        rdc(CPCOND_A_COUNT, 32'h0000fffe);
        rdc(CPCOND_A_TARGET, 32'h00000ffe);
        run_ins(16'hf081, 1, 16'h0000, 16'h0, 3'h4, 32'h0, 16'hf081,
            9'h0, 1'b1);
        run_ins(16'hfa95, 1, 16'h0010, 16'h0, 3'h0, 32'h1004, 16'hfa95,
            9'h0, 1'b0);
        ignored(16'hf1c0);
        ignored(16'h7081);
        complete_run();
    end
endmodule
